// ===== sae_eval.v
// sae_eval.v: smoke level evaluator, filter, baseline, levels, apb.
// assumes: samples arrive on a valid/ready port, one clock, sync reset.
`timescale 1ns/1ps
`include "sae_map.vh"

module sae_eval
#(
  parameter SEC_CYCLES = `SAE_CLK_HZ
)
(
  // clock and reset
  input  wire                        clk_in,
  input  wire                        resetn_in,
  // apb slave
  input  wire                        psel_in,
  input  wire                        penable_in,
  input  wire                        pwrite_in,
  input  wire [7:0]                  paddr_in,
  input  wire [31:0]                 pwdata_in,
  output reg  [31:0]                 prdata_out,
  output wire                        pready_out,
  output reg                         pslverr_out,
  // sample stream from the loop
  input  wire                        sample_valid_in,
  input  wire [`SAE_DET_W-1:0]       sample_det_in,
  input  wire [`SAE_VAL_W-1:0]       sample_val_in,
  output wire                        sample_ready_out,
  // time channel and alarm triggers
  input  wire                        time_chan_in,
  output reg  [`SAE_DETS-1:0]        pre_out,
  output reg  [`SAE_DETS-1:0]        fire_out,
  output reg  [`SAE_DETS-1:0]        heavy_out,
  output wire                        irq_out
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam S_INIT = 2'h0;
  localparam S_IDLE = 2'h1;
  localparam S_RD   = 2'h2;
  localparam S_UPD  = 2'h3;

  localparam [`SAE_SEC_W-1:0] SEC_LAST =
    SEC_CYCLES[`SAE_SEC_W-1:0] - 1'b1;

  reg [1:0]                  state_reg;
  reg [`SAE_DET_W-1:0]       det_reg;
  reg [`SAE_VAL_W-1:0]       val_reg;
  reg [1:0]                  ctrl_reg;
  reg [`SAE_VAL_W-1:0]       preoff_reg;
  reg [`SAE_VAL_W-1:0]       fireoff_reg;
  reg [`SAE_VAL_W-1:0]       hvyoff_reg;
  reg [`SAE_ALG_ALL_W-1:0]   algn_reg;
  reg [`SAE_ALG_ALL_W-1:0]   alga_reg;
  reg [`SAE_EV_W-1:0]        istat_reg;
  reg [`SAE_EV_W-1:0]        ien_reg;
  reg [`SAE_SEC_W-1:0]       cyc_reg;
  reg [`SAE_TS_W-1:0]        now_reg;
  reg [`SAE_HOUR_W-1:0]      hsec_reg;
  reg [`SAE_DETS-1:0]        hpend_reg;
  wire [`SAE_WORD_W-1:0]     rdata;
  reg  [`SAE_WORD_W-1:0]     wdata;

  // ----------------------------------------------------------------
  // per-detector memory
  // ----------------------------------------------------------------
  sae_mem u_mem
  (
    .clk_in    (clk_in),
    .we_in     ((state_reg == S_INIT) || (state_reg == S_UPD)),
    .waddr_in  (det_reg),
    .wdata_in  (wdata),
    .raddr_in  (det_reg),      // loop lines may move once taken
    .rdata_out (rdata)
  );

  // word layout: dec, base, sum, hour count, armed, arm stamp
  wire [`SAE_VAL_W-1:0]  m_dec   = rdata[`SAE_W_DEC];
  wire [`SAE_VAL_W-1:0]  m_base  = rdata[`SAE_W_BASE];
  wire [`SAE_SUM_W-1:0]  m_sum   = rdata[`SAE_W_SUM];
  wire [`SAE_HCNT_W-1:0] m_hcnt  = rdata[`SAE_W_HCNT];
  wire                   m_armed = rdata[`SAE_W_ARMED];
  wire [`SAE_TS_W-1:0]   m_ts    = rdata[`SAE_W_TS];

  // ----------------------------------------------------------------
  // algorithm select and step value
  // ----------------------------------------------------------------
  wire alt_on = time_chan_in | ctrl_reg[`SAE_CTRL_ALTSW];
  wire [`SAE_ALG_W-1:0] alg = alt_on ?
    alga_reg[det_reg*`SAE_ALG_W +: `SAE_ALG_W] :
    algn_reg[det_reg*`SAE_ALG_W +: `SAE_ALG_W];
  wire slow = alg[`SAE_ALG_SLOW];

  reg [`SAE_VAL_W-1:0] step;
  // slow time uses one small step for every sensitivity
  always @*
  begin
    if (slow)
      step = `SAE_STEP_SLOW;
    else
      case (alg[1:0])
        `SAE_SENS_HIGH: step = `SAE_STEP_H15;
        `SAE_SENS_LOW:  step = `SAE_STEP_L15;
        default:        step = `SAE_STEP_N15;
      endcase
  end

  // ----------------------------------------------------------------
  // decision filter
  // ----------------------------------------------------------------
  wire up = val_reg >= m_dec;
  wire [`SAE_VAL_W-1:0] diff = up ? val_reg - m_dec : m_dec - val_reg;
  wire [`SAE_VAL_W-1:0] dec_new = (diff <= step) ? val_reg :
    (up ? m_dec + step : m_dec - step);

  // ----------------------------------------------------------------
  // levels; nine bits so a high baseline cannot wrap a level low
  // ----------------------------------------------------------------
  wire [8:0] fire_lvl = {1'b0, m_base} + {1'b0, fireoff_reg};
  wire [8:0] pre_raw  = {1'b0, m_base} + {1'b0, preoff_reg};
  wire [8:0] hvy_raw  = {1'b0, m_base} + {1'b0, hvyoff_reg};
  wire [8:0] pre_lvl  = (pre_raw < fire_lvl) ? pre_raw : fire_lvl;
  wire [8:0] hvy_lvl  = (hvy_raw > fire_lvl) ? hvy_raw : fire_lvl;
  wire [8:0] dec9     = {1'b0, dec_new};
  wire at_pre  = dec9 >= pre_lvl;
  wire at_fire = dec9 >= fire_lvl;
  wire at_hvy  = dec9 >= hvy_lvl;

  // fire must stay at level for the algorithm's least delay
  wire [`SAE_TS_W-1:0] delay = slow ? `SAE_T_SLOW_S : `SAE_T_NORM_S;
  wire [`SAE_TS_W-1:0] held  = now_reg - m_ts;
  wire armed_new = at_fire;
  wire [`SAE_TS_W-1:0] ts_new = m_armed ? m_ts : now_reg;
  wire fire_ok = at_fire & m_armed & (held >= delay);
  wire pre_ok  = at_pre & ctrl_reg[`SAE_CTRL_PREEN];
  wire hvy_ok  = fire_ok & at_hvy;

  // ----------------------------------------------------------------
  // hourly average of decision values
  // ----------------------------------------------------------------
  wire hour_take = hpend_reg[det_reg];
  wire [`SAE_SUM_W-1:0] sum_add = m_sum + {7'h00, dec_new};
  wire hcnt_full = &m_hcnt;
  wire [`SAE_VAL_W-1:0] base_new = (hour_take & hcnt_full) ?
    sum_add[`SAE_SUM_W-1:`SAE_HCNT_W] : m_base;
  wire [`SAE_SUM_W-1:0] sum_new = !hour_take ? m_sum :
    (hcnt_full ? {`SAE_SUM_W{1'b0}} : sum_add);
  wire [`SAE_HCNT_W-1:0] hcnt_new = hour_take ? m_hcnt + 7'h01 : m_hcnt;

  // zeros during the sweep start every decision value at nought
  always @*
  begin
    if (state_reg == S_INIT)
      wdata = {`SAE_WORD_W{1'b0}};
    else
      wdata = {dec_new, base_new, sum_new, hcnt_new, armed_new, ts_new};
  end

  // ----------------------------------------------------------------
  // sequencing: one sample in flight, others wait on ready
  // ----------------------------------------------------------------
  assign sample_ready_out = (state_reg == S_IDLE);

  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state_reg <= S_INIT;
      det_reg   <= {`SAE_DET_W{1'b0}};
      val_reg   <= {`SAE_VAL_W{1'b0}};
    end
    else
      case (state_reg)
        S_INIT:
        begin
          det_reg <= det_reg + 3'h1;
          if (&det_reg)
            state_reg <= S_IDLE;
        end
        S_IDLE:
          if (sample_valid_in)
          begin
            det_reg   <= sample_det_in;
            val_reg   <= sample_val_in;
            state_reg <= S_RD;
          end
        S_RD:
          state_reg <= S_UPD;
        S_UPD:
          state_reg <= S_IDLE;
        default:
          state_reg <= S_IDLE;
      endcase
  end

  // ----------------------------------------------------------------
  // seconds and hour ticks
  // ----------------------------------------------------------------
  wire sec_tick  = (cyc_reg == SEC_LAST);
  wire hour_tick = sec_tick && (hsec_reg == `SAE_HOUR_S - 12'h001);

  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      cyc_reg   <= {`SAE_SEC_W{1'b0}};
      now_reg   <= {`SAE_TS_W{1'b0}};
      hsec_reg  <= {`SAE_HOUR_W{1'b0}};
      hpend_reg <= {`SAE_DETS{1'b0}};
    end
    else
    begin
      cyc_reg <= sec_tick ? {`SAE_SEC_W{1'b0}} : cyc_reg + 27'h1;
      if (sec_tick)
      begin
        now_reg  <= now_reg + 16'h0001;
        hsec_reg <= hour_tick ? {`SAE_HOUR_W{1'b0}} : hsec_reg + 12'h001;
      end
      // a fresh hour wins over the take of the previous one
      if (hour_tick)
        hpend_reg <= {`SAE_DETS{1'b1}};
      else if (state_reg == S_UPD)
        hpend_reg[det_reg] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per-detector trigger flags, not latched
  // ----------------------------------------------------------------
  wire [`SAE_DETS-1:0] ev_pre;
  wire [`SAE_DETS-1:0] ev_fire;
  wire [`SAE_DETS-1:0] ev_hvy;

  genvar g;
  generate
    for (g = 0; g < `SAE_DETS; g = g + 1)
    begin : g_det
      wire hit = (state_reg == S_UPD) && (det_reg == g);
      assign ev_pre[g]  = hit & pre_ok  & ~pre_out[g];
      assign ev_fire[g] = hit & fire_ok & ~fire_out[g];
      assign ev_hvy[g]  = hit & hvy_ok  & ~heavy_out[g];
      always @(posedge clk_in)
      begin
        if (!resetn_in)
        begin
          pre_out[g]   <= 1'b0;
          fire_out[g]  <= 1'b0;
          heavy_out[g] <= 1'b0;
        end
        else if (hit)
        begin
          pre_out[g]   <= pre_ok;
          fire_out[g]  <= fire_ok;
          heavy_out[g] <= hvy_ok;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // apb registers and interrupt
  // ----------------------------------------------------------------
  wire wr_acc = psel_in & penable_in & pwrite_in;
  wire [`SAE_EV_W-1:0] ev = {|ev_hvy, |ev_fire, |ev_pre};
  wire [`SAE_EV_W-1:0] iclr = (wr_acc && paddr_in == `SAE_OFF_ICLR) ?
    pwdata_in[`SAE_EV_W-1:0] : {`SAE_EV_W{1'b0}};

  assign pready_out = 1'b1;
  assign irq_out    = |(istat_reg & ien_reg);

  reg [31:0] rd_mux;
  reg        rd_bad;
  // decode once; the same map answers reads and flags stray addresses
  always @*
  begin
    rd_bad = 1'b0;
    case (paddr_in)
      `SAE_OFF_CTRL:    rd_mux = {30'h0, ctrl_reg};
      `SAE_OFF_PREOFF:  rd_mux = {24'h0, preoff_reg};
      `SAE_OFF_FIREOFF: rd_mux = {24'h0, fireoff_reg};
      `SAE_OFF_HVYOFF:  rd_mux = {24'h0, hvyoff_reg};
      `SAE_OFF_ALGN:    rd_mux = {8'h0, algn_reg};
      `SAE_OFF_ALGA:    rd_mux = {8'h0, alga_reg};
      `SAE_OFF_STATE:   rd_mux = {8'h0, heavy_out, fire_out, pre_out};
      `SAE_OFF_ISTAT:   rd_mux = {29'h0, istat_reg};
      `SAE_OFF_IEN:     rd_mux = {29'h0, ien_reg};
      `SAE_OFF_ICLR:    rd_mux = 32'h0;
      default:
      begin
        rd_mux = 32'h0;
        rd_bad = 1'b1;
      end
    endcase
  end

  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      ctrl_reg    <= `SAE_RST_CTRL;
      preoff_reg  <= `SAE_RST_PREOFF;
      fireoff_reg <= `SAE_RST_FIREOFF;
      hvyoff_reg  <= `SAE_RST_HVYOFF;
      algn_reg    <= {`SAE_DETS{`SAE_ALG_DEFAULT}};
      alga_reg    <= {`SAE_DETS{`SAE_ALG_DEFAULT}};
      istat_reg   <= {`SAE_EV_W{1'b0}};
      ien_reg     <= {`SAE_EV_W{1'b0}};
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      // data and error are captured in setup so they stand in access
      if (psel_in && !penable_in)
      begin
        prdata_out  <= pwrite_in ? 32'h0 : rd_mux;
        pslverr_out <= rd_bad;
      end
      if (wr_acc)
        case (paddr_in)
          `SAE_OFF_CTRL:    ctrl_reg    <= pwdata_in[`SAE_CTRL_W-1:0];
          `SAE_OFF_PREOFF:  preoff_reg  <= pwdata_in[7:0];
          `SAE_OFF_FIREOFF: fireoff_reg <= pwdata_in[7:0];
          `SAE_OFF_HVYOFF:  hvyoff_reg  <= pwdata_in[7:0];
          `SAE_OFF_ALGN:    algn_reg    <= pwdata_in[`SAE_ALG_ALL_W-1:0];
          `SAE_OFF_ALGA:    alga_reg    <= pwdata_in[`SAE_ALG_ALL_W-1:0];
          `SAE_OFF_IEN:     ien_reg     <= pwdata_in[`SAE_EV_W-1:0];
          default:          ien_reg     <= ien_reg;
        endcase
      // a new event in the clear cycle survives the clear
      istat_reg <= (istat_reg & ~iclr) | ev;
    end
  end

endmodule // sae_eval

// ===== sae_map.vh
// sae_map.vh: constants shared by the smoke level evaluator files.
// assumes: included by bare name from each design file.
`ifndef SAE_MAP_VH
`define SAE_MAP_VH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define SAE_DETS        8
`define SAE_DET_W       3
`define SAE_VAL_W       8
`define SAE_ALG_W       3
`define SAE_ALG_ALL_W   24
`define SAE_TS_W        16
`define SAE_SUM_W       15
`define SAE_HCNT_W      7
`define SAE_WORD_W      55
`define SAE_CTRL_W      2

// ----------------------------------------------------------------
// state word fields: dec, base, sum, hour count, armed, arm stamp
// ----------------------------------------------------------------
`define SAE_W_DEC       54:47
`define SAE_W_BASE      46:39
`define SAE_W_SUM       38:24
`define SAE_W_HCNT      23:17
`define SAE_W_ARMED     16
`define SAE_W_TS        15:0

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SAE_OFF_CTRL    8'h00
`define SAE_OFF_PREOFF  8'h04
`define SAE_OFF_FIREOFF 8'h08
`define SAE_OFF_HVYOFF  8'h0C
`define SAE_OFF_ALGN    8'h10
`define SAE_OFF_ALGA    8'h14
`define SAE_OFF_STATE   8'h18
`define SAE_OFF_ISTAT   8'h1C
`define SAE_OFF_IEN     8'h20
`define SAE_OFF_ICLR    8'h24

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SAE_CTRL_PREEN  0
`define SAE_CTRL_ALTSW  1
`define SAE_RST_CTRL    2'h1
`define SAE_RST_PREOFF  8'h16
`define SAE_RST_FIREOFF 8'h1E
`define SAE_RST_HVYOFF  8'h3C
`define SAE_ALG_DEFAULT 3'h0
`define SAE_EV_W        3
`define SAE_EV_PRE      0
`define SAE_EV_FIRE     1
`define SAE_EV_HVY      2

// ----------------------------------------------------------------
// algorithm code: bit 2 selects slow time, bits 1:0 sensitivity
// ----------------------------------------------------------------
`define SAE_SENS_NORM   2'h0
`define SAE_SENS_HIGH   2'h1
`define SAE_SENS_LOW    2'h2
`define SAE_ALG_SLOW    2
`define SAE_STEP_H15    8'h04
`define SAE_STEP_N15    8'h05
`define SAE_STEP_L15    8'h06
`define SAE_STEP_SLOW   8'h02

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SAE_CLK_HZ      100000000
`define SAE_T_NORM_S    16'h000F
`define SAE_T_SLOW_S    16'h0023
`define SAE_HOUR_S      12'hE10
`define SAE_HOUR_W      12
`define SAE_SEC_W       27

`endif

// ===== sae_mem.v
// sae_mem.v: per-detector state memory, one word per detector.
// assumes: single clock, read data valid the cycle after the address.
`timescale 1ns/1ps
`include "sae_map.vh"

module sae_mem
(
  // clock
  input  wire                        clk_in,
  // write port
  input  wire                        we_in,
  input  wire [`SAE_DET_W-1:0]       waddr_in,
  input  wire [`SAE_WORD_W-1:0]      wdata_in,
  // read port
  input  wire [`SAE_DET_W-1:0]       raddr_in,
  output reg  [`SAE_WORD_W-1:0]      rdata_out
);

  reg [`SAE_WORD_W-1:0] mem_reg [0:`SAE_DETS-1];

  // no reset here: the owner sweeps zeros in after reset
  always @(posedge clk_in)
  begin
    if (we_in)
      mem_reg[waddr_in] <= wdata_in;
    rdata_out <= mem_reg[raddr_in];
  end

endmodule // sae_mem

// ===== sae_eval_monitor.sv
// sae_eval_monitor.sv: port assertions for the smoke level evaluator.
// assumes: bound to sae_eval; one clock, sync active-low reset.
`timescale 1ns/1ps
`include "sae_map.vh"

module sae_eval_monitor
#(
  parameter SEC_CYCLES = 10
)
(
  // clock and reset
  input wire                 clk_in,
  input wire                 resetn_in,
  // apb
  input wire                 psel_in,
  input wire                 penable_in,
  input wire                 pwrite_in,
  input wire [7:0]           paddr_in,
  input wire                 pready_out,
  input wire                 pslverr_out,
  // samples and triggers
  input wire                 sample_valid_in,
  input wire                 sample_ready_out,
  input wire [`SAE_DETS-1:0] pre_out,
  input wire [`SAE_DETS-1:0] fire_out,
  input wire [`SAE_DETS-1:0] heavy_out,
  input wire                 irq_out
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // write access and sample take, named once for the properties
  wire wr_acc = psel_in && penable_in && pwrite_in;
  wire take   = sample_valid_in && sample_ready_out;

  chk_apb_nowait: assert property (pready_out)
    else $error("apb slave inserted a wait state");
  chk_heavy_fire: assert property ((heavy_out & ~fire_out) == 8'h00)
    else $error("heavy smoke without fire alarm");
  chk_sample_gap: assert property (take |=> !sample_ready_out [*2] ##1 sample_ready_out)
    else $error("sample port pacing wrong");
  chk_flag_cause: assert property ($changed({pre_out, fire_out, heavy_out}) |-> $past(take, 3))
    else $error("trigger changed without a sample three edges back");
  chk_irq_rise: assert property ($rose(irq_out) |-> $past(wr_acc) || $changed({pre_out, fire_out, heavy_out}))
    else $error("irq rose without event or enable write");
  chk_irq_fall: assert property ($fell(irq_out) |-> $past(wr_acc))
    else $error("irq fell without a register write");
  chk_bad_addr: assert property (psel_in && penable_in && paddr_in > 8'h24 |-> pslverr_out)
    else $error("unmapped access without slave error");
  chk_init_sweep: assert property ($rose(resetn_in) |-> !sample_ready_out [*6])
    else $error("samples taken during state clearing");
endmodule // sae_eval_monitor

// ===== sae_loop_model.sv
// sae_loop_model.sv: detector loop model feeding samples to the block.
// assumes: bench raises req_in with a detector and value, waits taken_out.
`timescale 1ns/1ps
`include "sae_map.vh"

module sae_loop_model
(
  // clock and reset
  input  wire                  clk_in,
  input  wire                  resetn_in,
  // command from the bench
  input  wire                  req_in,
  input  wire [`SAE_DET_W-1:0] det_in,
  input  wire [`SAE_VAL_W-1:0] val_in,
  output reg                   taken_out,
  // loop side of the evaluator
  output reg                   sample_valid_out,
  output reg  [`SAE_DET_W-1:0] sample_det_out,
  output reg  [`SAE_VAL_W-1:0] sample_val_out,
  input  wire                  sample_ready_in
);
  // ----------------------------------------------------------------
  // offer one sample, hold it until taken
  // ----------------------------------------------------------------
  // released lines are inverted so a stale value never looks valid
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      sample_valid_out <= 1'b0;
      taken_out        <= 1'b0;
      sample_det_out   <= 3'h0;
      sample_val_out   <= 8'h00;
    end
    else if (sample_valid_out && sample_ready_in)
    begin
      sample_valid_out <= 1'b0;
      taken_out        <= 1'b1;
      sample_det_out   <= ~sample_det_out;
      sample_val_out   <= ~sample_val_out;
    end
    else
    begin
      taken_out <= 1'b0;
      if (req_in && !sample_valid_out && !taken_out)
      begin
        sample_valid_out <= 1'b1;
        sample_det_out   <= det_in; // addressed per detector
        sample_val_out   <= val_in;
      end
    end
  end
endmodule // sae_loop_model

// ===== sae_eval_tb.sv
// sae_eval_tb.sv: self-checking bench for the smoke level evaluator.
// assumes: sae_eval, sae_loop_model and sae_eval_monitor compiled first.
`timescale 1ns/1ps
`include "sae_map.vh"

module sae_eval_tb;
  typedef struct {logic [2:0] alg; int npre; int tsec;} sae_row_t;
  localparam int SECC = 10; // one second is ten clocks to keep runs short
  reg                   clk_in = 1'b0;
  reg                   resetn_in = 1'b0;
  reg                   psel = 1'b0;
  reg                   penable = 1'b0;
  reg                   pwrite = 1'b0;
  reg  [7:0]            paddr = 8'h00;
  reg  [31:0]           pwdata = 32'h0;
  reg                   req = 1'b0;
  reg  [2:0]            det_c = 3'h0;
  reg  [7:0]            val_c = 8'h00;
  reg                   tchan = 1'b0;
  wire [31:0]           prdata;
  wire                  pready;
  wire                  pslverr;
  wire                  s_valid;
  wire [2:0]            s_det;
  wire [7:0]            s_val;
  wire                  s_ready;
  wire                  taken;
  wire [7:0]            pre;
  wire [7:0]            fire;
  wire [7:0]            heavy;
  wire                  irq;
  int                   n_fail = 0;
  int                   checks_done = 0;
  int                   i;
  int                   k;
  int                   dt;
  time                  t0;
  reg  [31:0]           q;
  reg                   e;
  reg  [31:0]           algn = 32'h0;
  sae_row_t             rows [6];
  logic [31:0]          rv [11] = '{1, 'h16, 'h1E, 'h3C, 0, 0, 0, 0, 0, 0, 0};

  always #5 clk_in = ~clk_in;

  sae_eval #(.SEC_CYCLES(SECC)) sae_eval_i
  (
    .clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .sample_valid_in(s_valid),
    .sample_det_in(s_det), .sample_val_in(s_val),
    .sample_ready_out(s_ready), .time_chan_in(tchan), .pre_out(pre),
    .fire_out(fire), .heavy_out(heavy), .irq_out(irq)
  );

  sae_loop_model sae_loop_model_i
  (
    .clk_in(clk_in), .resetn_in(resetn_in), .req_in(req),
    .det_in(det_c), .val_in(val_c), .taken_out(taken),
    .sample_valid_out(s_valid), .sample_det_out(s_det),
    .sample_val_out(s_val), .sample_ready_in(s_ready)
  );

  // ----------------------------------------------------------------
  // report tasks
  // ----------------------------------------------------------------
  task results;
    begin
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task tmo;
    begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      results;
    end
  endtask

  task ck(input [31:0] got, input [31:0] exp, input string what);
    begin
      checks_done++;
      if (got !== exp)
      begin
        n_fail++;
        $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // bus and sample tasks
  // ----------------------------------------------------------------
  // apb: setup, access, hold until pready sampled high
  task apb(input w, input [7:0] a, input [31:0] d, output [31:0] r,
           output er);
    int n;
    begin
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      n = 0;
      @(posedge clk_in);
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge clk_in);
        n++;
      end
      if (n == 20)
        tmo;
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // one sample; returns where its flags have settled
  task smp(input [2:0] d, input [7:0] v);
    int n;
    begin
      @(posedge clk_in);
      req <= 1'b1;
      det_c <= d;
      val_c <= v;
      n = 0;
      @(negedge clk_in);
      while (taken !== 1'b1 && n < 50)
      begin
        @(negedge clk_in);
        n++;
      end
      if (n == 50)
        tmo;
      @(posedge clk_in);
      req <= 1'b0;
      @(posedge clk_in);
      @(negedge clk_in);
    end
  endtask

  task rst;
    begin
      @(posedge clk_in);
      resetn_in <= 1'b0;
      repeat (12) @(posedge clk_in);
      @(negedge clk_in);
      ck({pre, fire, heavy, irq, s_ready, pready}, 32'h1, "reset out");
      @(posedge clk_in);
      resetn_in <= 1'b1;
      k = 0;
      while (s_ready !== 1'b1 && k < 20)
      begin
        @(negedge clk_in);
        k++;
      end
      if (k == 20)
        tmo;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rows = '{'{3'h0, 4, 15}, '{3'h1, 5, 15}, '{3'h2, 4, 15},
             '{3'h4, 10, 35}, '{3'h5, 10, 35}, '{3'h6, 10, 35}};
    rst;
    // register reset values, last word unmapped
    for (i = 0; i < 11; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0, q, e);
      ck(q, rv[i], "reset value");
      ck(e, i == 10, "slave error");
      algn = algn | (i < 6 ? 32'(rows[i].alg) << (3 * i) : 32'h0);
    end
    // pre level 20 so that some algorithms land exactly on it
    apb(1'b1, `SAE_OFF_PREOFF, 32'h14, q, e);
    apb(1'b1, `SAE_OFF_ALGN, algn, q, e);
    apb(1'b1, `SAE_OFF_ALGA, 32'h4 << 21, q, e);
    // one row per algorithm, each on its own detector from zero
    for (i = 0; i < 6; i++)
    begin
      t0 = $time;
      k = 0;
      while (pre[i] !== 1'b1 && k < 20)
      begin
        smp(i, 8'h64);
        k++;
      end
      ck(k, rows[i].npre, "pre steps");
      while (fire[i] !== 1'b1 && k < 200)
      begin
        smp(i, 8'h64);
        k++;
      end
      dt = int'(($time - t0) / 10);
      ck(dt >= rows[i].tsec * SECC - SECC, 1, "fire early");
      ck(dt <= rows[i].tsec * SECC + 100, 1, "fire late");
      while (heavy[i] !== 1'b1 && k < 250)
      begin
        smp(i, 8'h64);
        k++;
      end
      ck(heavy[i], 1, "heavy");
      ck(fire >> (i + 1), 0, "other dets");
      k = 0;
      while (pre[i] !== 1'b0 && k < 60)
      begin
        smp(i, 8'h00);
        k++;
      end
      ck({pre[i], fire[i], heavy[i]}, 0, "clear");
    end
    // events are sticky but masked until enabled
    ck(irq, 0, "masked irq");
    apb(1'b0, `SAE_OFF_ISTAT, 32'h0, q, e);
    ck(q, 7, "event bits");
    apb(1'b1, `SAE_OFF_IEN, 32'h4, q, e);
    @(negedge clk_in);
    ck(irq, 1, "irq on");
    apb(1'b1, `SAE_OFF_ICLR, 32'h7, q, e);
    apb(1'b0, `SAE_OFF_ISTAT, 32'h0, q, e);
    ck({q, irq}, 0, "irq clear");
    apb(1'b0, `SAE_OFF_ICLR, 32'h0, q, e);
    ck(q, 0, "clear reads 0");
    // time channel selects the slow alternative on detector 7
    tchan <= 1'b1;
    k = 0;
    while (pre[7] !== 1'b1 && k < 20)
    begin
      smp(7, 8'h64);
      k++;
    end
    ck(k, 10, "alt steps");
    apb(1'b1, `SAE_OFF_CTRL, 32'h0, q, e);
    repeat (8) smp(6, 8'h64);
    ck(pre[6], 0, "pre disabled");
    // software alt select: slow step stays under pre level 24 from 20
    apb(1'b1, `SAE_OFF_CTRL, 32'h3, q, e);
    tchan <= 1'b0;
    apb(1'b1, `SAE_OFF_PREOFF, 32'h18, q, e);
    smp(7, 8'h64);
    ck(pre[7], 0, "soft alt step");
    rst;
    results;
  end

  // overall watchdog, counted as a mismatch
  initial
  begin
    repeat (100000) @(posedge clk_in);
    tmo;
  end
endmodule // sae_eval_tb

bind sae_eval sae_eval_monitor #(.SEC_CYCLES(SEC_CYCLES)) sae_eval_monitor_i
(
  .clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .sample_valid_in(sample_valid_in), .sample_ready_out(sample_ready_out),
  .pre_out(pre_out), .fire_out(fire_out), .heavy_out(heavy_out),
  .irq_out(irq_out)
);
